// ---- csb_unit.sv ----
// compare, skip and branch execution unit
`timescale 1ns/10ps
module csb_unit
	import csb_pkg::*;
(
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst,
	// decoded instruction and core state
	input  wire csb_instr_t   instr,
	input  wire logic [PC_W-1:0] pcIn,
	input  wire logic [7:0]   statusIn,
	input  wire logic [7:0]   ioData,
	// results
	output csb_result_t       result
);
	////////////////////////////////////////////////////////////////////////
	// operation classes
	logic            isCmp;
	logic            isCarryCmp;
	logic            isSkip;
	logic            isBranch;
	logic            isNone;
	// compare datapath
	logic [7:0]      cmpStatus;
	logic [7:0]      subtrahend;
	logic            borrow;
	logic            chainZero;
	// skip and branch conditions
	logic            skipBit;
	logic            skipWant;
	logic            skip;
	logic [2:0]      branchIdx;
	logic            branchWant;
	logic            taken;
	// program counter candidates
	logic [PC_W-1:0] offsetExt;
	logic [PC_W-1:0] target;
	logic [PC_W-1:0] skipPc;
	logic [PC_W-1:0] stepPc;
	logic [PC_W-1:0] skipPick;
	logic [PC_W-1:0] branchPick;
	// next values of the answer
	logic            done_d;
	logic            pcLoad_d;
	logic [PC_W-1:0] pcNext_d;
	logic            flagWrite_d;
	logic [7:0]      status_d;
	// registered answer
	logic            done_q;
	logic            pcLoad_q;
	logic [PC_W-1:0] pcNext_q;
	logic            flagWrite_q;
	logic [7:0]      status_q;

	////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [PC_W-1:0] addPc(input logic [PC_W-1:0] pc, input int step);
		addPc = pc + step[PC_W-1:0];
	endfunction

	function automatic logic bitAt(input logic [7:0] word, input logic [2:0] sel);
		bitAt = word[sel];
	endfunction

	// true when the selected bit sits at the level that triggers the jump
	function automatic logic flagHit(input logic [7:0] word, input logic [2:0] sel,
		input logic want);
		flagHit = (bitAt(word, sel) == want);
	endfunction

	// offset sign-extended so backward branches reach lower addresses
	function automatic logic [PC_W-1:0] extendOffset(input logic [OFF_W-1:0] off);
		extendOffset = {{(PC_W-OFF_W){off[OFF_W-1]}}, off};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// operation class decode
	always_comb begin
		isCmp = 1'b0;
		isCarryCmp = 1'b0;
		isSkip = 1'b0;
		isBranch = 1'b0;
		isNone = 1'b0;
		case (instr.op)
			CSB_OP_NONE: begin
				isNone = 1'b1;
			end

			CSB_OP_COMPARE_WITH_CARRY: begin
				isCmp = 1'b1;
				isCarryCmp = 1'b1;
			end

			CSB_OP_COMPARE_IMMEDIATE: begin
				isCmp = 1'b1;
			end

			CSB_OP_SKIP_REG_BIT_CLEAR,
			CSB_OP_SKIP_REG_BIT_SET,
			CSB_OP_SKIP_IO_BIT_CLEAR,
			CSB_OP_SKIP_IO_BIT_SET: begin
				isSkip = 1'b1;
			end

			default: begin
				// every remaining code is a branch
				isBranch = 1'b1;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// compare datapath
	// carry compare borrows C and chains Z; immediate swaps in the constant
	always_comb begin
		subtrahend = instr.regR;
		borrow = 1'b0;
		chainZero = 1'b1;
		if (isCarryCmp) begin
			borrow = statusIn[FLAG_C];
			chainZero = statusIn[FLAG_Z];
		end else if (isCmp) begin
			subtrahend = instr.imm;
		end
	end

	// one subtractor serves both compares
	csb_sub8 u_sub (
		.minuend    (instr.regD),
		.subtrahend (subtrahend),
		.borrowIn   (borrow),
		.chainZero  (chainZero),
		.statusIn   (statusIn),
		.statusOut  (cmpStatus)
	);

	////////////////////////////////////////////////////////////////////////
	// skip condition: which bit, and the level that skips
	always_comb begin
		skipBit = 1'b0;
		skipWant = 1'b1;
		case (instr.op)
			CSB_OP_SKIP_REG_BIT_CLEAR: begin
				skipBit = bitAt(instr.regR, instr.bitSel);
				skipWant = 1'b0;
			end

			CSB_OP_SKIP_REG_BIT_SET: begin
				skipBit = bitAt(instr.regR, instr.bitSel);
				skipWant = 1'b1;
			end

			CSB_OP_SKIP_IO_BIT_CLEAR: begin
				skipBit = bitAt(ioData, instr.bitSel);
				skipWant = 1'b0;
			end

			CSB_OP_SKIP_IO_BIT_SET: begin
				skipBit = bitAt(ioData, instr.bitSel);
				skipWant = 1'b1;
			end

			default: begin
				skipBit = 1'b0;
				skipWant = 1'b1;
			end
		endcase
	end

	assign skip = isSkip && (skipBit == skipWant);

	////////////////////////////////////////////////////////////////////////
	// branch condition: which status bit, and the level that takes the branch
	always_comb begin
		branchIdx = 3'(FLAG_Z);
		branchWant = 1'b1;
		case (instr.op)
			CSB_OP_BRANCH_FLAG_SET: begin
				branchIdx = instr.bitSel;
				branchWant = 1'b1;
			end

			CSB_OP_BRANCH_FLAG_CLEAR: begin
				// signed-ge and plus share this code and test N as printed, not N^V
				if (instr.signedGe || instr.branchPlus) begin
					branchIdx = 3'(FLAG_N);
				end else begin
					branchIdx = instr.bitSel;
				end
				branchWant = 1'b0;
			end

			CSB_OP_BRANCH_EQUAL: begin
				branchIdx = 3'(FLAG_Z);
				branchWant = 1'b1;
			end

			CSB_OP_BRANCH_NOT_EQUAL: begin
				branchIdx = 3'(FLAG_Z);
				branchWant = 1'b0;
			end

			CSB_OP_BRANCH_CARRY_SET: begin
				branchIdx = 3'(FLAG_C);
				branchWant = 1'b1;
			end

			CSB_OP_BRANCH_CARRY_CLEAR: begin
				branchIdx = 3'(FLAG_C);
				branchWant = 1'b0;
			end

			CSB_OP_BRANCH_SAME_HIGHER: begin
				branchIdx = 3'(FLAG_C);
				branchWant = 1'b0;
			end

			CSB_OP_BRANCH_LOWER: begin
				branchIdx = 3'(FLAG_C);
				branchWant = 1'b1;
			end

			CSB_OP_BRANCH_MINUS: begin
				branchIdx = 3'(FLAG_N);
				branchWant = 1'b1;
			end

			default: begin
				branchIdx = 3'(FLAG_Z);
				branchWant = 1'b1;
			end
		endcase
	end

	assign taken = isBranch && flagHit(statusIn, branchIdx, branchWant);

	////////////////////////////////////////////////////////////////////////
	// program counter candidates
	always_comb begin
		offsetExt = extendOffset(instr.offset);
		target = pcIn + offsetExt + PC_W'(STEP_ONE);
		skipPc = instr.nextIsTwoWord ? addPc(pcIn, SKIP_TWO)
			: addPc(pcIn, SKIP_ONE);
		stepPc = addPc(pcIn, STEP_ONE);
	end

	// skip pick: two or three words ahead when the condition holds, else one
	always_comb begin
		skipPick = stepPc;
		if (skip) begin
			skipPick = skipPc;
		end
	end

	// branch pick: relative target when taken, else fall through
	always_comb begin
		branchPick = stepPc;
		if (taken) begin
			branchPick = target;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// next answer; an empty slot answers nothing
	always_comb begin
		done_d = 1'b0;
		pcLoad_d = 1'b0;
		flagWrite_d = 1'b0;
		if (instr.valid) begin
			done_d = 1'b1;
			// compares leave the program counter to the core's own increment
			pcLoad_d = ~(isNone | isCmp);
			flagWrite_d = isCmp;
		end
	end

	always_comb begin
		pcNext_d = '0;
		if (instr.valid && isSkip) begin
			pcNext_d = skipPick;
		end else if (instr.valid && isBranch) begin
			pcNext_d = branchPick;
		end
	end

	always_comb begin
		// skips and branches pass the flags through untouched
		status_d = statusIn;
		if (instr.valid && isCmp) begin
			status_d = cmpStatus;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registered answer; one cycle latency keeps outputs glitch free
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			done_q <= 1'b0;
		end else begin
			done_q <= done_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pcLoad_q <= 1'b0;
		end else begin
			pcLoad_q <= pcLoad_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pcNext_q <= PC_RST;
		end else begin
			pcNext_q <= pcNext_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			flagWrite_q <= 1'b0;
		end else begin
			flagWrite_q <= flagWrite_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			status_q <= STATUS_RST;
		end else begin
			status_q <= status_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output assembly, straight from the registers
	always_comb begin
		result.done = done_q;
		result.pcLoad = pcLoad_q;
		result.pcNext = pcNext_q;
		result.flagWrite = flagWrite_q;
		result.status = status_q;
	end
endmodule

// ---- csb_pkg.sv ----
// package for the compare, skip and branch unit
package csb_pkg;
	localparam int PC_W      = 16;
	localparam int OFF_W     = 7;
	localparam int SKIP_ONE  = 2;
	localparam int SKIP_TWO  = 3;
	localparam int STEP_ONE  = 1;
	// status register bit positions
	localparam int FLAG_C    = 0;
	localparam int FLAG_Z    = 1;
	localparam int FLAG_N    = 2;
	localparam int FLAG_V    = 3;
	localparam int FLAG_S    = 4;
	localparam int FLAG_H    = 5;
	localparam logic [7:0]      STATUS_RST = 8'h00;
	localparam logic [PC_W-1:0] PC_RST     = 16'h0000;

	typedef enum logic [3:0] {
		CSB_OP_NONE               = 4'h0,
		CSB_OP_COMPARE_WITH_CARRY = 4'h1,
		CSB_OP_COMPARE_IMMEDIATE  = 4'h2,
		CSB_OP_SKIP_REG_BIT_CLEAR = 4'h3,
		CSB_OP_SKIP_REG_BIT_SET   = 4'h4,
		CSB_OP_SKIP_IO_BIT_CLEAR  = 4'h5,
		CSB_OP_SKIP_IO_BIT_SET    = 4'h6,
		CSB_OP_BRANCH_FLAG_SET    = 4'h7,
		CSB_OP_BRANCH_FLAG_CLEAR  = 4'h8,
		CSB_OP_BRANCH_EQUAL       = 4'h9,
		CSB_OP_BRANCH_NOT_EQUAL   = 4'ha,
		CSB_OP_BRANCH_CARRY_SET   = 4'hb,
		CSB_OP_BRANCH_CARRY_CLEAR = 4'hc,
		CSB_OP_BRANCH_SAME_HIGHER = 4'hd,
		CSB_OP_BRANCH_LOWER       = 4'he,
		CSB_OP_BRANCH_MINUS       = 4'hf
	} csb_op_t;

	// one decoded instruction from the decoder
	typedef struct packed {
		logic             valid;
		csb_op_t          op;
		logic             signedGe;
		logic             branchPlus;
		logic [7:0]       regD;
		logic [7:0]       regR;
		logic [7:0]       imm;
		logic [2:0]       bitSel;
		logic [OFF_W-1:0] offset;
		logic             nextIsTwoWord;
	} csb_instr_t;

	// answer toward program counter and status register
	typedef struct packed {
		logic            done;
		logic            pcLoad;
		logic [PC_W-1:0] pcNext;
		logic            flagWrite;
		logic [7:0]      status;
	} csb_result_t;
endpackage

// ---- csb_sub8.sv ----
// 8-bit subtractor with borrow and flag generation
`timescale 1ns/10ps
module csb_sub8
	import csb_pkg::*;
(
	// operands
	input  wire logic [7:0] minuend,
	input  wire logic [7:0] subtrahend,
	input  wire logic       borrowIn,
	input  wire logic       chainZero,
	input  wire logic [7:0] statusIn,
	// flags out
	output logic [7:0]      statusOut
);
	logic [8:0] diff;
	logic [7:0] r;
	logic       c;
	logic       h;
	logic       v;
	logic       n;
	logic       z;

	always_comb begin
		diff = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrowIn};
		r = diff[7:0];
		c = (~minuend[7] & subtrahend[7]) | (subtrahend[7] & r[7]) | (r[7] & ~minuend[7]);
		h = (~minuend[3] & subtrahend[3]) | (subtrahend[3] & r[3]) | (r[3] & ~minuend[3]);
		v = (minuend[7] & ~subtrahend[7] & ~r[7]) | (~minuend[7] & subtrahend[7] & r[7]);
		n = r[7];
		// zero is chained so a multi-byte compare only stays zero if all bytes were
		z = (r == 8'h00) & chainZero;
		statusOut = statusIn;
		statusOut[FLAG_C] = c;
		statusOut[FLAG_H] = h;
		statusOut[FLAG_V] = v;
		statusOut[FLAG_N] = n;
		statusOut[FLAG_Z] = z;
		statusOut[FLAG_S] = n ^ v;
	end
endmodule

// ---- csb_unit_checker.sv ----
// assertion checker for the compare, skip and branch unit
`timescale 1ns/10ps
module csb_unit_checker
	import csb_pkg::*;
(
	// clock and reset
	input wire logic            core_clk,
	input wire logic            rst,
	// watched ports
	input wire csb_instr_t      instr,
	input wire logic [PC_W-1:0] pcIn,
	input wire logic [7:0]      statusIn,
	input wire logic [7:0]      ioData,
	input wire csb_result_t     result
);
	logic            v, rb, ib, eq, lt, fw, ld;
	csb_op_t         o;
	logic [7:0]      st;
	logic [PC_W-1:0] skT, brT, nx;
	assign v = instr.valid;
	assign o = instr.op;
	assign rb = instr.regR[instr.bitSel];
	assign ib = ioData[instr.bitSel];
	assign eq = instr.regD == instr.imm;
	assign lt = instr.regD < instr.imm;
	assign fw = result.flagWrite;
	assign ld = result.pcLoad;
	assign st = result.status;
	assign nx = result.pcNext;
	assign skT = pcIn + (instr.nextIsTwoWord ? 16'h0003 : 16'h0002);
	// offset sign extended so backward branches land below pcIn
	assign brT = pcIn + {{9{instr.offset[6]}}, instr.offset} + 16'h0001;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	property p_cpc; v && o == CSB_OP_COMPARE_WITH_CARRY |=> fw && !ld; endproperty
	a_cpc: assert property (p_cpc) else $error("compare with carry result");
	property p_cpi; v && o == CSB_OP_COMPARE_IMMEDIATE |=> fw && st[1:0] == $past({eq, lt}); endproperty
	a_cpi: assert property (p_cpi) else $error("compare immediate flags");
	property p_src; v && o == CSB_OP_SKIP_REG_BIT_CLEAR && !rb |=> nx == $past(skT) && !fw; endproperty
	a_src: assert property (p_src) else $error("reg bit clear skip");
	property p_srs; v && o == CSB_OP_SKIP_REG_BIT_SET && rb |=> nx == $past(skT) && !fw; endproperty
	a_srs: assert property (p_srs) else $error("reg bit set skip");
	property p_sic; v && o == CSB_OP_SKIP_IO_BIT_CLEAR && !ib |=> nx == $past(skT) && !fw; endproperty
	a_sic: assert property (p_sic) else $error("io bit clear skip");
	property p_sis; v && o == CSB_OP_SKIP_IO_BIT_SET && ib |=> nx == $past(skT) && !fw; endproperty
	a_sis: assert property (p_sis) else $error("io bit set skip");
	property p_bfs; v && o == CSB_OP_BRANCH_FLAG_SET && statusIn[instr.bitSel] |=> ld && nx == $past(brT); endproperty
	a_bfs: assert property (p_bfs) else $error("flag set branch");
	property p_beq; v && o == CSB_OP_BRANCH_EQUAL && statusIn[FLAG_Z] |=> ld && nx == $past(brT); endproperty
	a_beq: assert property (p_beq) else $error("equal branch");
	property p_bne; v && o == CSB_OP_BRANCH_NOT_EQUAL && statusIn[FLAG_Z] |=> nx == $past(pcIn) + 16'h0001; endproperty
	a_bne: assert property (p_bne) else $error("not equal fall through");
	c_cpc: cover property (v && o == CSB_OP_COMPARE_WITH_CARRY);
	c_two: cover property (v && o == CSB_OP_SKIP_IO_BIT_SET && ib && instr.nextIsTwoWord);
	c_b2b: cover property (v ##1 v);
endmodule
bind csb_unit csb_unit_checker csb_unit_checker_i (.core_clk(core_clk), .rst(rst), .instr(instr),
	.pcIn(pcIn), .statusIn(statusIn), .ioData(ioData), .result(result));

// ---- tb_csb_unit.sv ----
// self-checking bench for the compare, skip and branch unit
`timescale 1ns/10ps
module tb_csb_unit
	import csb_pkg::*;
;
	typedef struct {int dn; int ld; int fw; int nx; int st;} csb_exp_t;
	logic            core_clk = 1'b0;
	logic            rst = 1'b1;
	csb_instr_t      instr = '0;
	logic [PC_W-1:0] pcIn = '0;
	logic [7:0]      statusIn = '0;
	logic [7:0]      ioData = '0;
	csb_result_t     result;
	int              n_errors = 0;
	int              checked = 0;
	int              seed = 16736;
	logic [63:0]     rnd;
	csb_exp_t        q[$];
	csb_unit csb_unit_i (.core_clk(core_clk), .rst(rst), .instr(instr), .pcIn(pcIn),
		.statusIn(statusIn), .ioData(ioData), .result(result));
	initial begin
		forever #10 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////
	function automatic csb_exp_t model(csb_instr_t i, int pc, logic [7:0] st, logic [7:0] io);
		int d, r, c, w, vf, t, k;
		csb_op_t o;
		o = i.op;
		d = i.regD;
		c = (o == CSB_OP_COMPARE_WITH_CARRY) ? st[FLAG_C] : 0;
		r = (o == CSB_OP_COMPARE_WITH_CARRY) ? i.regR : i.imm;
		w = (d - r - c) & 32'hff;
		vf = ((d ^ r) & (d ^ w) & 32'h80) != 0;
		t = (st & 32'hc0) + (d < r + c) + (w >> 7) * 4 + vf * 8 + ((w >> 7) ^ vf) * 16;
		t += (w == 0 && (c == 0 && o != CSB_OP_COMPARE_WITH_CARRY || st[FLAG_Z])) * 2;
		t += ((d & 32'hf) < (r & 32'hf) + c) * 32;
		if (!i.valid) return '{0, -1, -1, -1, -1};
		if (o == CSB_OP_NONE) return '{1, 0, 0, -1, st};
		if (o <= CSB_OP_COMPARE_IMMEDIATE) return '{1, 0, 1, -1, t};
		case (o)
			CSB_OP_SKIP_REG_BIT_CLEAR: k = !i.regR[i.bitSel];
			CSB_OP_SKIP_REG_BIT_SET: k = i.regR[i.bitSel];
			CSB_OP_SKIP_IO_BIT_CLEAR: k = !io[i.bitSel];
			CSB_OP_SKIP_IO_BIT_SET: k = io[i.bitSel];
			CSB_OP_BRANCH_FLAG_SET: k = st[i.bitSel];
			// as printed: the signed variant tests only the negative flag
			CSB_OP_BRANCH_FLAG_CLEAR: k = (i.signedGe || i.branchPlus) ? !st[FLAG_N] : !st[i.bitSel];
			CSB_OP_BRANCH_EQUAL: k = st[FLAG_Z];
			CSB_OP_BRANCH_NOT_EQUAL: k = !st[FLAG_Z];
			CSB_OP_BRANCH_CARRY_SET, CSB_OP_BRANCH_LOWER: k = st[FLAG_C];
			CSB_OP_BRANCH_CARRY_CLEAR, CSB_OP_BRANCH_SAME_HIGHER: k = !st[FLAG_C];
			default: k = st[FLAG_N];
		endcase
		if (o <= CSB_OP_SKIP_IO_BIT_SET) return '{1, 1, 0, (pc + 1 + k * (1 + i.nextIsTwoWord)), st};
		return '{1, 1, 0, (pc + 1 + k * int'($signed(i.offset))) & 32'hffff, st};
	endfunction
	task automatic cmp(input string nm, input logic [15:0] seen, input int ex);
		checked++;
		if (seen !== 16'(ex)) begin
			n_errors++;
			$display("unexpected %s: expected %0h, seen %0h", nm, 16'(ex), seen);
		end
	endtask
	task automatic check(input csb_exp_t e);
		cmp("done", 16'(result.done), e.dn);
		if (e.ld >= 0) cmp("pcLoad", 16'(result.pcLoad), e.ld);
		if (e.fw >= 0) cmp("flagWrite", 16'(result.flagWrite), e.fw);
		if (e.nx >= 0) cmp("pcNext", result.pcNext, e.nx);
		if (e.st >= 0) cmp("status", 16'(result.status), e.st);
	endtask
	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		repeat (2200) @(posedge core_clk);
		n_errors++;
		wrap_up();
	end
	initial begin
		repeat (6) @(posedge core_clk);
		#1;
		cmp("reset done", 16'(result.done), 0);
		rst = 1'b0;
		repeat (2000) begin
			@(posedge core_clk);
			#1;
			if (q.size() > 0) check(q.pop_front());
			rnd = {$random(seed), $random(seed)};
			instr = rnd[41:0];
			instr.valid = |rnd[43:42];
			pcIn = rnd[59:44];
			statusIn = 8'($random(seed));
			ioData = 8'($random(seed));
			q.push_back(model(instr, pcIn, statusIn, ioData));
		end
		wrap_up();
	end
endmodule
